/* design/sdram_init_pkg.sv */
// shared constants and types for the sdram init and mode programming block
package sdram_init_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // mode register storage
    localparam int          MODE_REG_COUNT = 7;         // registers zero to six
    localparam int          MODE_REG_WIDTH = 18;        // address bits 17:0
    localparam logic [2:0]  MODE_SEL_LAST  = 3'h6;      // code 111 is not a register
    localparam logic [17:0] MODE_IMPL_MASK = 18'h1FFFF; // bit 17 not built in this bin
    localparam int          DLL_RESET_BIT  = 8;         // loop reset field in register zero
    localparam int          CAL_LONG_BIT   = 10;        // address bit that marks the long calibration

    ////////////////////////////////////////////////////////////////////////////
    // wait times, in clock cycles (writable defaults)
    localparam logic [15:0] LOCK_CYCLES_RST = 16'h0300; // loop lock time
    localparam logic [15:0] CAL_CYCLES_RST  = 16'h0400; // initial calibration time

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [7:0]  STATUS_OFS    = 8'h00;
    localparam logic [7:0]  REFCOUNT_OFS  = 8'h04;
    localparam logic [7:0]  LOCKCFG_OFS   = 8'h08;
    localparam logic [7:0]  CALCFG_OFS    = 8'h0C;
    localparam logic [7:0]  MODEREG0_OFS  = 8'h10;      // registers zero..six, one word each
    localparam logic [7:0]  MODEREG6_OFS  = 8'h28;
    localparam logic [31:0] ZERO_WORD     = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer states
    typedef enum logic [2:0]
    {
        ST_HOLD    = 3'b000,   // device reset pin held low
        ST_WAITCKE = 3'b001,   // reset released, clock gate still low
        ST_PROGRAM = 3'b010,   // mode register writes expected
        ST_CALIB   = 3'b011,   // long calibration and loop lock running
        ST_READY   = 3'b100    // normal operation
    } seqState_t;

    // command codes seen on the strobe pins {rowStrobeN, colStrobeN, writeEnN}
    localparam logic [2:0] CMD_MODE_WRITE = 3'b000;
    localparam logic [2:0] CMD_REFRESH    = 3'b001;
    localparam logic [2:0] CMD_CALIB      = 3'b110;

    typedef logic [MODE_REG_WIDTH-1:0] modeWord_t;

    typedef struct packed
    {
        logic [15:0] count;
        logic        done;
    } timerState_t;

    typedef struct packed
    {
        logic [15:0] lockCfg;
        logic [15:0] calCfg;
        logic [31:0] rdata;
        logic        slvErr;
    } apbState_t;

endpackage

/* design/wait_timer.sv */
// down counter that raises done when a programmed number of cycles has passed
`timescale 1ns/1ps
module wait_timer
    import sdram_init_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clear,     // drops done and stops the count
    input  wire logic        start,     // loads the count
    input  wire logic [15:0] cycles,    // wait length, zero treated as one
    output logic             done       // level, held until clear or start
);

    timerState_t state_r;   // registered state
    timerState_t state_nxt; // next state

    ////////////////////////////////////////////////////////////////////////////
    // next state: start wins over clear so a restart is never lost
    always_comb
    begin
        state_nxt = state_r;
        if (start)
        begin
            state_nxt.count = (cycles == 16'h0000) ? 16'h0001 : cycles;
            state_nxt.done  = 1'b0;
        end
        else if (clear)
        begin
            state_nxt.count = 16'h0000;
            state_nxt.done  = 1'b0;
        end
        else if (state_r.count != 16'h0000)
        begin
            // done rises the cycle the last count is spent
            state_nxt.count = state_r.count - 16'h0001;
            state_nxt.done  = (state_r.count == 16'h0001);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign done = state_r.done;

endmodule

/* design/apb_regs.sv */
// apb slave holding the wait settings and returning the sequencer status
`timescale 1ns/1ps
module apb_regs
    import sdram_init_pkg::*;
(
    input  wire logic                             clk,
    input  wire logic                             resetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [7:0]                       paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic [31:0]                      statusWord,   // live sequencer status
    input  wire logic [31:0]                      refreshCount, // refresh commands seen
    input  wire logic [MODE_REG_COUNT-1:0][17:0]  modeRegs,     // stored mode registers
    output logic      [15:0]                      lockCycles,   // loop lock wait
    output logic      [15:0]                      calCycles     // calibration wait
);

    apbState_t state_r;   // registered state
    apbState_t state_nxt; // next state
    logic      setup;     // setup phase, data latched for the access phase
    logic [4:0] modeIdx;  // word index into the mode register block

    ////////////////////////////////////////////////////////////////////////////
    // decode in the setup phase, answer in the access phase with no wait state
    always_comb
    begin
        modeIdx   = 5'h00;
        state_nxt = state_r;
        setup     = psel && !penable;
        if (setup)
        begin
            state_nxt.rdata  = ZERO_WORD;
            state_nxt.slvErr = 1'b0;
            modeIdx          = 5'((paddr - MODEREG0_OFS) >> 2);
            if (paddr[1:0] != 2'h0)
                state_nxt.slvErr = 1'b1;
            else if (paddr == STATUS_OFS)
                state_nxt.rdata = statusWord;
            else if (paddr == REFCOUNT_OFS)
                state_nxt.rdata = refreshCount;
            else if (paddr == LOCKCFG_OFS)
                state_nxt.rdata = {16'h0000, state_r.lockCfg};
            else if (paddr == CALCFG_OFS)
                state_nxt.rdata = {16'h0000, state_r.calCfg};
            else if (paddr >= MODEREG0_OFS && paddr <= MODEREG6_OFS)
                state_nxt.rdata = {14'h0000, modeRegs[modeIdx[2:0]]};
            else
                state_nxt.slvErr = 1'b1; // unmapped
            // writes to read-only words are refused the same way
            if (pwrite && paddr != LOCKCFG_OFS && paddr != CALCFG_OFS)
                state_nxt.slvErr = 1'b1;
        end
        // write lands on the access edge only
        if (psel && penable && pwrite)
        begin
            if (paddr == LOCKCFG_OFS)
                state_nxt.lockCfg = pwdata[15:0];
            if (paddr == CALCFG_OFS)
                state_nxt.calCfg = pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r         <= '0;
            state_r.lockCfg <= LOCK_CYCLES_RST;
            state_r.calCfg  <= CAL_CYCLES_RST;
        end
        else
            state_r <= state_nxt;
    end

    assign prdata     = state_r.rdata;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && state_r.slvErr;
    assign lockCycles = state_r.lockCfg;
    assign calCycles  = state_r.calCfg;

endmodule

/* design/sdram_init_seq.sv */
// device-side reset, initialization and mode register programming logic
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sdram_init_seq
    import sdram_init_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        memResetN,     // device reset pin, active low
    input  wire logic        clockGate,     // clock gate input
    input  wire logic        chipSelN,      // chip select, active low
    input  wire logic        rowStrobeN,    // row strobe, active low
    input  wire logic        colStrobeN,    // column strobe, active low
    input  wire logic        writeEnN,      // write enable, active low
    input  wire logic [1:0]  bankGroup,     // bank group address
    input  wire logic [1:0]  bankAddr,      // bank address
    input  wire logic [17:0] addr,          // row/column address
    input  wire logic        testEnablePin, // test enable pin
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             deviceReady    // normal operation allowed
);

    ////////////////////////////////////////////////////////////////////////////
    // types and state

    typedef struct packed
    {
        seqState_t                               seq;          // sequencer state
        logic [MODE_REG_COUNT-1:0][17:0]         modeRegs;     // stored mode registers
        logic [MODE_REG_COUNT-1:0]               written;      // registers written since reset
        logic [31:0]                             refreshCount; // survives device reset
        logic [7:0]                              badCmds;      // mode writes refused, cleared by reset
        logic                                    ready;        // registered ready output
    } seqRegs_t;

    seqRegs_t    state_r;      // registered state
    seqRegs_t    state_nxt;    // next state
    logic        modeWrite;    // mode register write on the pins this cycle
    logic        refreshCmd;   // refresh on the pins this cycle
    logic        calLong;      // long calibration on the pins this cycle
    logic [2:0]  modeSel;      // target register code
    logic        lockStart;    // loop reset written, start lock wait
    logic        calStart;     // calibration begins
    logic        lockDone;     // loop lock time spent
    logic        calDone;      // calibration time spent
    logic        timerClear;   // device reset clears both timers
    logic [15:0] lockCycles;   // programmed lock wait
    logic [15:0] calCycles;    // programmed calibration wait
    logic [31:0] statusWord;   // status seen by software
    logic        cmdSlot;      // chip selected, clock gate high, out of device reset
    logic [2:0]  strobes;      // {rowStrobeN, colStrobeN, writeEnN}

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    // true when a command slot is open and the strobes carry the given code;
    // every pin comes in as an argument so the decode follows each pin change
    function automatic logic isCmd(input logic slot, input logic [2:0] pins, input logic [2:0] code);
        isCmd = slot && (pins == code);
    endfunction

    // a slot needs chip select low, the clock gate high and the device out of reset
    assign cmdSlot    = memResetN && !chipSelN && clockGate;
    assign strobes    = {rowStrobeN, colStrobeN, writeEnN};

    // register code sits on bank group bit 0 and both bank address bits
    assign modeSel    = {bankGroup[0], bankAddr};
    assign modeWrite  = isCmd(cmdSlot, strobes, CMD_MODE_WRITE);
    assign refreshCmd = isCmd(cmdSlot, strobes, CMD_REFRESH);
    assign calLong    = isCmd(cmdSlot, strobes, CMD_CALIB) && addr[CAL_LONG_BIT];
    assign timerClear = !memResetN;

    // the loop lock wait runs from a loop reset written to register zero;
    // a write refused in hold or waitcke starts nothing, just as it stores nothing
    assign lockStart = modeWrite && (modeSel == 3'h0) && addr[DLL_RESET_BIT]
                       && (state_r.seq != ST_HOLD) && (state_r.seq != ST_WAITCKE);
    // calibration runs from the long calibration command, in any state but hold or waitcke
    assign calStart  = calLong && (state_r.seq != ST_HOLD) && (state_r.seq != ST_WAITCKE);

    ////////////////////////////////////////////////////////////////////////////
    // wait timers

    wait_timer lockTimer
    (
        .clk    (clk),
        .resetn (resetn),
        .clear  (timerClear),
        .start  (lockStart),
        .cycles (lockCycles),
        .done   (lockDone)
    );

    wait_timer calTimer
    (
        .clk    (clk),
        .resetn (resetn),
        .clear  (timerClear),
        .start  (calStart),
        .cycles (calCycles),
        .done   (calDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer and mode register store
    always_comb
    begin
        state_nxt = state_r;

        // writes leave this alone
        // refresh count is kept across device reset
        if (refreshCmd)
            state_nxt.refreshCount = state_r.refreshCount + 32'h00000001;

        if (!memResetN)
        begin
            // reset clears the refused count
            // everything but the refresh count is cleared while the pin is low
            state_nxt.seq      = ST_HOLD;
            state_nxt.modeRegs = '0;
            state_nxt.written  = '0;
            state_nxt.badCmds  = 8'h00;
            state_nxt.ready    = 1'b0;
        end
        else
        begin
            // write only by command
            // code 111 names no register and is dropped
            if (modeWrite && modeSel <= MODE_SEL_LAST && state_r.seq != ST_HOLD && state_r.seq != ST_WAITCKE)
            begin
                state_nxt.modeRegs[modeSel] = addr & MODE_IMPL_MASK;
                state_nxt.written[modeSel]  = 1'b1;
            end
            else if (modeWrite)
                state_nxt.badCmds = state_r.badCmds + 8'h01;

            case (state_r.seq)
                ST_HOLD:
                    state_nxt.seq = ST_WAITCKE;
                ST_WAITCKE:
                begin
                    if (clockGate)
                        state_nxt.seq = ST_PROGRAM;
                end
                ST_PROGRAM:
                begin
                    if (calLong)
                        state_nxt.seq = ST_CALIB;
                end
                ST_CALIB:
                begin
                    if (lockDone && calDone)
                    begin
                        state_nxt.seq   = ST_READY;
                        state_nxt.ready = 1'b1;
                    end
                end
                ST_READY:
                begin
                    // rewrites keep device ready
                    // mode writes are stored above; the state does not move
                    state_nxt.ready = 1'b1;
                end
                default:
                begin
                    state_nxt.seq   = ST_HOLD;
                    state_nxt.ready = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r     <= '0;
            state_r.seq <= ST_HOLD;
        end
        else
            state_r <= state_nxt;
    end

    assign deviceReady = state_r.ready;

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    // status: state, ready, timer flags, test pin, written mask, refused count
    assign statusWord = {8'h00, state_r.badCmds, 1'b0, state_r.written,
                         testEnablePin, calDone, lockDone, state_r.ready, 1'b0, state_r.seq};

    apb_regs regs
    (
        .clk          (clk),
        .resetn       (resetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .statusWord   (statusWord),
        .refreshCount (state_r.refreshCount),
        .modeRegs     (state_r.modeRegs),
        .lockCycles   (lockCycles),
        .calCycles    (calCycles)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // the ready output only rises once both waits have run out
    ready_after_waits_a: assert property ($rose(state_r.ready) |-> $past(lockDone) && $past(calDone))
        else $error("ready rose before lock and calibration waits ended");

    // ready never rises without a long calibration having started first
    ready_needs_cal_a: assert property (state_r.seq == ST_PROGRAM && !calLong |=> !state_r.ready)
        else $error("ready while still programming");

    // device reset empties the written mask and the refused count
    reset_clears_a: assert property (!memResetN |=> state_r.written == '0 && state_r.badCmds == 8'h00 && !lockDone)
        else $error("device reset left a counter standing");

    // refresh count holds through device reset unless a refresh arrives
    refresh_kept_a: assert property (!memResetN && !refreshCmd |=> $stable(state_r.refreshCount))
        else $error("device reset disturbed the refresh count");

    // an accepted mode write stores the address into the chosen register
    mode_store_a: assert property (memResetN && modeWrite && modeSel <= MODE_SEL_LAST && state_r.seq >= ST_PROGRAM
        |=> state_r.modeRegs[$past(modeSel)] == ($past(addr) & MODE_IMPL_MASK))
        else $error("mode write not stored");

    // out of device reset, code 111 and non-write cycles leave all mode registers alone
    mode_only_cmd_a: assert property (memResetN && (!modeWrite || modeSel > MODE_SEL_LAST)
        |=> $stable(state_r.modeRegs))
        else $error("mode registers changed without a write command");

    // a mode write in normal operation leaves the device ready two cycles later
    ready_holds_a: assert property (state_r.ready && modeWrite && memResetN ##1 memResetN [*2]
        |-> state_r.ready)
        else $error("mode write in normal operation dropped ready");

    // mode writes never touch the refresh count, which survives device reset
    array_untouched_a: assert property (modeWrite && !refreshCmd |=> $stable(state_r.refreshCount))
        else $error("mode write disturbed stored state");

    // unimplemented bits of register zero are always stored as zero
    impl_mask_a: assert property ((state_r.modeRegs[0] & ~MODE_IMPL_MASK) == 18'h00000)
        else $error("unimplemented mode bit stored");

    // device reset puts the sequencer back to hold with ready low
    hold_on_reset_a: assert property (!memResetN |=> state_r.seq == ST_HOLD && !state_r.ready)
        else $error("device reset did not return to hold");

    // a refused mode write is counted once and stored nowhere
    refused_count_a: assert property (modeWrite && (modeSel > MODE_SEL_LAST || state_r.seq == ST_HOLD
        || state_r.seq == ST_WAITCKE) |=> state_r.badCmds == $past(state_r.badCmds) + 8'h01)
        else $error("refused mode write not counted");

    // restarting the lock wait drops its done flag at once
    lock_restart_a: assert property (lockStart |=> !lockDone)
        else $error("loop lock wait not restarted");

    // long calibration in normal operation reruns the wait but keeps ready
    cal_rerun_a: assert property (state_r.ready && calStart |=> !calDone && state_r.ready)
        else $error("calibration rerun dropped ready or kept done");

endmodule

/* sim/ctrl_model.sv */
// behavioural memory controller that drives the command pins of the init block
`timescale 1ns/1ps
module ctrl_model
    import sdram_init_pkg::*;
#(
    parameter int GAP_CYCLES   = 4,  // mode write cycle time, scaled down
    parameter int PULSE_CYCLES = 4,  // reset pulse width, scaled down
    parameter int GATE_WAIT    = 5   // wait from reset release to clock gate, scaled
)
(
    input  wire logic        clk,
    output logic             memResetN,
    output logic             clockGate,
    output logic             chipSelN,
    output logic             rowStrobeN,
    output logic             colStrobeN,
    output logic             writeEnN,
    output logic [1:0]       bankGroup,
    output logic [1:0]       bankAddr,
    output logic [17:0]      addr,
    output logic             testEnablePin
);
    ////////////////////////////////////////////////////////////////////////////
    // pins idle at time zero: device held in reset, nothing selected
    // test pin low
    initial
    begin
        memResetN     = 1'b0;
        clockGate     = 1'b0;
        chipSelN      = 1'b1;
        {rowStrobeN, colStrobeN, writeEnN} = 3'b111;
        bankGroup     = 2'b00;
        bankAddr      = 2'b00;
        addr          = 18'h00000;
        testEnablePin = 1'b0;
    end

    // pulse, then gate
    // clock gate goes low with the pulse, so it is low long before release
    task automatic power_up();
        clockGate <= 1'b0;
        memResetN <= 1'b0;
        repeat (PULSE_CYCLES) @(posedge clk);
        memResetN <= 1'b1;
        repeat (GATE_WAIT) @(posedge clk);
        clockGate <= 1'b1;
        @(posedge clk);
    endtask

    // command, then deselects
    // bank and address lines are inverted while deselected so no stale value can pass for a command
    task automatic issue(input logic [2:0] cmd, input logic [2:0] sel, input logic [17:0] a);
        chipSelN  <= 1'b0;
        {rowStrobeN, colStrobeN, writeEnN} <= cmd;
        bankGroup <= {1'b0, sel[2]};
        bankAddr  <= sel[1:0];
        addr      <= a;
        @(posedge clk);
        chipSelN  <= 1'b1;
        {rowStrobeN, colStrobeN, writeEnN} <= 3'b111;
        bankGroup <= ~{1'b0, sel[2]};
        bankAddr  <= ~sel[1:0];
        addr      <= ~a;
        repeat (GAP_CYCLES) @(posedge clk);
    endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the sdram init and mode programming block
`timescale 1ns/1ps
module testbench
    import sdram_init_pkg::*;
;
    logic        clk, resetn, psel, penable, pwrite;   // apb and system inputs
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, deviceReady, err;
    wire         memResetN, clockGate, chipSelN, rowStrobeN, colStrobeN, writeEnN, testEnablePin;
    wire  [1:0]  bankGroup, bankAddr;
    wire  [17:0] addr;
    int          error_cnt, tests_run, n;                // verdict counters
    typedef struct { logic [2:0] sel; logic [17:0] val; logic [17:0] exp; } row_t;
    row_t        rows [7];                               // mode write, expected readback

    ctrl_model ctl (.clk(clk), .memResetN(memResetN), .clockGate(clockGate), .chipSelN(chipSelN),
        .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN), .bankGroup(bankGroup),
        .bankAddr(bankAddr), .addr(addr), .testEnablePin(testEnablePin));
    sdram_init_seq dut (.clk(clk), .resetn(resetn), .memResetN(memResetN), .clockGate(clockGate),
        .chipSelN(chipSelN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN),
        .bankGroup(bankGroup), .bankAddr(bankAddr), .addr(addr), .testEnablePin(testEnablePin), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .deviceReady(deviceReady));

    ////////////////////////////////////////////////////////////////////////////
    // 100 ns clock
    always #50 clk = ~clk;

    // one compare, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // apb transfer; an idle edge after it keeps two requests from colliding in one step
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp,
                       input logic expErr);
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        chk(32'(err), 32'(expErr));
        if (!wr && !expErr)
            chk(rd, exp);
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // whole run is a few hundred cycles; this only cuts a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {clk, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        // every register, one before zero, zero carries loop reset
        rows = '{'{3'h3, 18'h00008, 18'h00008}, '{3'h6, 18'h3FFFF, 18'h1FFFF}, '{3'h5, 18'h00A05, 18'h00A05},
                 '{3'h4, 18'h10002, 18'h10002}, '{3'h2, 18'h00028, 18'h00028}, '{3'h1, 18'h00001, 18'h00001},
                 '{3'h0, 18'h2A9F5, 18'h0A9F5}};
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        acc(0, LOCKCFG_OFS, 0, 32'h00000300, 0);
        acc(0, CALCFG_OFS, 0, 32'h00000400, 0);
        acc(1, LOCKCFG_OFS, 32'h00000028, 0, 0);   // lock wait dominates the ready time
        acc(1, CALCFG_OFS, 32'h00000004, 0, 0);
        acc(0, 8'h2C, 0, 0, 1);
        acc(1, STATUS_OFS, 32'h00000001, 0, 1);
        ctl.power_up();
        acc(0, STATUS_OFS, 0, 32'h00000002, 0);
        foreach (rows[i])
        begin
            ctl.issue(CMD_MODE_WRITE, rows[i].sel, rows[i].val);
            acc(0, MODEREG0_OFS + {3'b000, rows[i].sel, 2'b00}, 0, 32'(rows[i].exp), 0);
        end
        ctl.issue(CMD_CALIB, 3'h0, 18'h00400);
        repeat (22) @(posedge clk);
        chk(32'(deviceReady), 32'h0);
        n = 0;
        while (deviceReady !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(deviceReady), 32'h1);
        ctl.issue(CMD_MODE_WRITE, 3'h7, 18'h00011);
        ctl.issue(CMD_MODE_WRITE, 3'h2, 18'h01234);
        acc(0, MODEREG0_OFS + 8'h08, 0, 32'h00001234, 0);
        acc(0, STATUS_OFS, 0, 32'h00017F74, 0);
        // loop reset and long calibration rerun in normal operation: ready stays, lock wait restarts
        ctl.issue(CMD_MODE_WRITE, 3'h0, 18'h00100);
        ctl.issue(CMD_CALIB, 3'h0, 18'h00400);
        chk(32'(deviceReady), 32'h1);
        acc(0, STATUS_OFS, 0, 32'h00017F54, 0);
        repeat (3) ctl.issue(CMD_REFRESH, 3'h0, 18'h00000);
        // second pulse, whole init owed again
        ctl.power_up();
        acc(0, REFCOUNT_OFS, 0, 32'h00000003, 0);
        acc(0, MODEREG0_OFS + 8'h08, 0, 32'h00000000, 0);
        acc(0, STATUS_OFS, 0, 32'h00000002, 0);
        finish_test();
    end
endmodule
